/* File: compare_skip_and_return_exec_bench.sv */
// Self-checking bench for the compare-skip and return execution block
module compare_skip_and_return_exec_bench;
   import csr_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, srst = 1, instrValid = 0, nextIsTwoWord = 0;
   logic [15:0] instr = 16'h0000;
   csr_ctx_t shadowCtx = '0;
   logic [11:0] fileAddr, fa;
   logic fileRd, stackPop, discardFetch, busy, rd;
   logic [7:0] fileData, workingRegister, statusReg, pcUpperLatch;
   logic [7:0] pcHighLatch;
   logic [3:0] bankSelectRegister;
   logic [20:0] topOfStack, pc;
   logic [1:0] quarter;
   logic [4:0] nDisc, nPop, nBusy;
   int num_errors = 0, n_checks = 0;
   always #4 clk = ~clk;
   csr_exec dut (.clk(clk), .srst(srst), .instr(instr),
      .instrValid(instrValid), .nextIsTwoWord(nextIsTwoWord),
      .fileAddr(fileAddr), .fileRd(fileRd), .fileData(fileData),
      .topOfStack(topOfStack), .stackPop(stackPop), .shadowCtx(shadowCtx),
      .workingRegister(workingRegister), .statusReg(statusReg),
      .bankSelectRegister(bankSelectRegister), .pc(pc),
      .pcUpperLatch(pcUpperLatch), .pcHighLatch(pcHighLatch),
      .discardFetch(discardFetch), .quarter(quarter), .busy(busy));
   csr_mem_model model (.clk(clk), .fileAddr(fileAddr), .fileRd(fileRd),
      .fileData(fileData), .topOfStack(topOfStack));
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Launch one instruction aligned to Q1 and count pipeline activity
   task automatic exec(input logic [15:0] w, input logic tw);
      nDisc = 0; nPop = 0; nBusy = 0;
      @(negedge clk);
      while (quarter !== Q1) @(negedge clk);
      // Word stands from Q1 through the Q4 edge that makes the decision
      instr = w; instrValid = 1; nextIsTwoWord = tw;
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         if (i == 0) begin
            fa = fileAddr; rd = fileRd;
            chk("quarter", quarter, Q2);
         end
         if (i == 3) instrValid = 0;
         nDisc += discardFetch; nPop += stackPop; nBusy += busy;
      end
   endtask
   task automatic cmp(input logic [2:0] sub, input logic a,
         input logic [7:0] ad, v, input logic tw, input int slots);
      logic [11:0] ea;
      ea = {a ? 4'h3 : ACCESS_BANK, ad};
      model.mem[ea] = v;
      exec({OP_CMP_HI, sub, a, ad}, tw);
      chk("fileRd", rd, 1'b1);
      chk("fileAddr", fa, ea);
      chk("discard", nDisc, 5'(4 * slots));
      chk("status", statusReg, 8'hA5);
      chk("working", workingRegister, 8'h50);
   endtask
   task automatic ret(input logic s, input csr_ctx_t sh, input csr_ctx_t ex,
         input logic [20:0] t);
      model.top_of_stack = t; shadowCtx = sh;
      exec({OP_RET, s}, 1'b0);
      chk("pc", pc, t);
      chk("pop", nPop, 5'h01);
      chk("busy", nBusy, 5'h04);
      chk("ctx", {workingRegister, statusReg, bankSelectRegister}, ex);
      chk("latches", {pcUpperLatch, pcHighLatch}, 16'h0000);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #16000;
      num_errors++;
      tally_and_finish;
   end
   initial begin
      repeat (10) @(negedge clk);
      srst = 0;
      ret(1'b1, '{8'h50, 8'hA5, 4'h3}, '{8'h50, 8'hA5, 4'h3}, 21'h01_2346);
      ret(1'b0, '{8'h11, 8'h22, 4'h9}, '{8'h50, 8'hA5, 4'h3}, 21'h00_0ABC);
      cmp(OP_LT_SUB, 1'b1, 8'h10, 8'h40, 1'b0, 1);
      cmp(OP_LT_SUB, 1'b0, 8'h11, 8'h50, 1'b0, 0);
      cmp(OP_LT_SUB, 1'b1, 8'h12, 8'h00, 1'b1, 2);
      cmp(OP_GT_SUB, 1'b0, 8'h13, 8'h80, 1'b0, 1);
      cmp(OP_GT_SUB, 1'b1, 8'h14, 8'h4F, 1'b1, 0);
      cmp(OP_GT_SUB, 1'b0, 8'h15, 8'hFF, 1'b1, 2);
      tally_and_finish;
   end
endmodule

/* File: csr_exec.sv */
// Compare-skip and return execution logic
module csr_exec
   import csr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Fetched instruction
   input wire logic [15:0] instr,
   input wire logic instrValid,
   input wire logic nextIsTwoWord,
   // File register read port
   output logic [11:0] fileAddr,
   output logic fileRd,
   input wire logic [7:0] fileData,
   // Return stack
   input wire logic [20:0] topOfStack,
   output logic stackPop,
   // Shadow registers
   input wire csr_ctx_t shadowCtx,
   // Core state
   output logic [7:0] workingRegister,
   output logic [7:0] statusReg,
   output logic [3:0] bankSelectRegister,
   output logic [20:0] pc,
   output logic [7:0] pcUpperLatch,
   output logic [7:0] pcHighLatch,
   // Pipeline
   output logic discardFetch,
   output logic [1:0] quarter,
   output logic busy
);
   logic cycleEnd;
   csr_state_t st_q, st_d;
   csr_ctx_t ctx_q, ctx_d;
   logic [20:0] pc_q, pc_d;
   logic [7:0] latU_q, latH_q;
   logic skip_q, skip_d;
   logic two_q, two_d;
   logic isLt, isGt, isRet;

   csr_quarter uQuarter (
      .clk(clk),
      .srst(srst),
      .quarter(quarter),
      .cycleEnd(cycleEnd)
   );

   always_comb begin
      isLt = instr[15:12] == OP_CMP_HI && instr[11:9] == OP_LT_SUB;
      isGt = instr[15:12] == OP_CMP_HI && instr[11:9] == OP_GT_SUB;
      isRet = instr[15:1] == OP_RET;
   end

   // Bank flag picks the register contents or the fixed access bank
   always_comb begin
      if (instr[BANK_BIT]) begin
         fileAddr = {bankSelectRegister, instr[7:0]};
      end else begin
         fileAddr = {ACCESS_BANK, instr[7:0]};
      end
   end

   assign fileRd = st_q == ST_EXEC && instrValid && quarter == Q2 &&
                   (isLt || isGt);

   always_comb begin
      st_d = st_q;
      ctx_d = ctx_q;
      pc_d = pc_q;
      skip_d = skip_q;
      two_d = two_q;
      stackPop = 1'b0;
      case (st_q)
         ST_EXEC: begin
            if (instrValid && quarter == Q3 && (isLt || isGt)) begin
               skip_d = isLt ? (fileData < ctx_q.working)
                             : (fileData > ctx_q.working);
               two_d = nextIsTwoWord;
            end
            if (instrValid && cycleEnd && isRet) begin
               stackPop = 1'b1;
               pc_d = topOfStack;
               if (instr[0]) begin
                  ctx_d = shadowCtx;
               end
               st_d = ST_RETNOP;
            end else if (instrValid && cycleEnd && skip_q) begin
               st_d = ST_SKIP1;
            end
         end
         ST_SKIP1: begin
            if (cycleEnd) begin
               skip_d = 1'b0;
               st_d = two_q ? ST_SKIP2 : ST_EXEC;
            end
         end
         ST_SKIP2: begin
            if (cycleEnd) begin
               two_d = 1'b0;
               st_d = ST_EXEC;
            end
         end
         ST_RETNOP: begin
            if (cycleEnd) begin
               st_d = ST_EXEC;
            end
         end
         default: begin
            st_d = ST_EXEC;
         end
      endcase
   end

   // Latches have no writer here; a return must not disturb them
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= ST_EXEC;
         ctx_q <= '{working: W_RST, status: W_RST, bank: BSR_RST};
         pc_q <= PC_RST;
         skip_q <= 1'b0;
         two_q <= 1'b0;
         latU_q <= W_RST;
         latH_q <= W_RST;
      end else begin
         st_q <= st_d;
         ctx_q <= ctx_d;
         pc_q <= pc_d;
         skip_q <= skip_d;
         two_q <= two_d;
         latU_q <= latU_q;
         latH_q <= latH_q;
      end
   end

   assign workingRegister = ctx_q.working;
   assign statusReg = ctx_q.status;
   assign bankSelectRegister = ctx_q.bank;
   assign pc = pc_q;
   assign pcUpperLatch = latU_q;
   assign pcHighLatch = latH_q;
   assign discardFetch = st_q != ST_EXEC;
   assign busy = st_q != ST_EXEC;

   sequence s_cmp_end;
      st_q == ST_EXEC && instrValid && cycleEnd && (isLt || isGt);
   endsequence

   a_skip_taken: assert property (@(posedge clk) disable iff (srst)
      s_cmp_end and skip_q |=> st_q == ST_SKIP1)
      else $error("skip not entered");
   a_no_skip: assert property (@(posedge clk) disable iff (srst)
      s_cmp_end and !skip_q |=> st_q == ST_EXEC)
      else $error("spurious skip");
   a_skip_nop: assert property (@(posedge clk) disable iff (srst)
      st_q == ST_SKIP1 && quarter == Q1 |-> discardFetch [*4])
      else $error("skip slot not full nop");
   a_two_word: assert property (@(posedge clk) disable iff (srst)
      st_q == ST_SKIP1 && cycleEnd && two_q |=> st_q == ST_SKIP2)
      else $error("second skip slot missing");
   a_ret_pc: assert property (@(posedge clk) disable iff (srst)
      stackPop |=> pc_q == $past(topOfStack) && st_q == ST_RETNOP)
      else $error("return pc wrong");
   a_ret_restore: assert property (@(posedge clk) disable iff (srst)
      stackPop && instr[0] |=> ctx_q == $past(shadowCtx))
      else $error("shadow restore wrong");
   a_ret_keep: assert property (@(posedge clk) disable iff (srst)
      stackPop && !instr[0] |=> $stable(ctx_q))
      else $error("context changed without restore");
   a_latch_keep: assert property (@(posedge clk) disable iff (srst)
      stackPop |=> $stable(latU_q) && $stable(latH_q))
      else $error("pc latch changed");
   a_ret_len: assert property (@(posedge clk) disable iff (srst)
      stackPop |=> busy [*4] ##1 !busy)
      else $error("return length wrong");
   a_bank_access: assert property (@(posedge clk) disable iff (srst)
      fileRd && !instr[BANK_BIT] |-> fileAddr[11:8] == ACCESS_BANK)
      else $error("access bank not used");
   a_read_q2: assert property (@(posedge clk) disable iff (srst)
      fileRd |-> quarter == Q2)
      else $error("read outside Q2");
   a_cmp_flags: assert property (@(posedge clk) disable iff (srst)
      st_q == ST_EXEC && !stackPop |=> $stable(ctx_q.status))
      else $error("status changed");
endmodule

/* File: csr_mem_model.sv */
// File register and return stack model facing the execution block
module csr_mem_model
   import csr_pkg::*;
(
   // Clock
   input wire logic clk,
   // File read and stack
   input wire logic [11:0] fileAddr,
   input wire logic fileRd,
   output logic [7:0] fileData,
   output logic [20:0] topOfStack
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [4096];
   logic [20:0] top_of_stack = 21'h00_0000;
   logic [7:0] dataQ = 8'h5A;
   assign topOfStack = top_of_stack;
   assign fileData = dataQ;
   // Data is held only for Q3; from Q4 on it flips to its inverse on every cycle, not held stale
   always @(posedge clk) begin
      dataQ <= fileRd ? mem[fileAddr] : ~dataQ;
   end
endmodule

/* File: csr_pkg.sv */
// Package for the compare-skip and return execution block
package csr_pkg;
   localparam logic [3:0] OP_CMP_HI = 4'h6;
   localparam logic [2:0] OP_LT_SUB = 3'h0;
   localparam logic [2:0] OP_GT_SUB = 3'h2;
   localparam logic [14:0] OP_RET = 15'h0009;
   localparam int BANK_BIT = 8;
   localparam logic [3:0] ACCESS_BANK = 4'h0;
   localparam logic [1:0] Q1 = 2'h0;
   localparam logic [1:0] Q2 = 2'h1;
   localparam logic [1:0] Q3 = 2'h2;
   localparam logic [1:0] Q4 = 2'h3;
   localparam logic [7:0] W_RST = 8'h00;
   localparam logic [3:0] BSR_RST = 4'h0;
   localparam logic [20:0] PC_RST = 21'h00_0000;

   typedef enum logic [3:0] {
      ST_EXEC = 4'b0001,
      ST_SKIP1 = 4'b0010,
      ST_SKIP2 = 4'b0100,
      ST_RETNOP = 4'b1000
   } csr_state_t;

   typedef struct packed {
      logic [7:0] working;
      logic [7:0] status;
      logic [3:0] bank;
   } csr_ctx_t;
endpackage

/* File: csr_quarter.sv */
// Quarter-cycle sequencer for the instruction cycle
module csr_quarter
   import csr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Quarter phase
   output logic [1:0] quarter,
   output logic cycleEnd
);
   logic [1:0] q_q;
   logic [1:0] q_d;

   always_comb begin
      q_d = q_q + 2'h1;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q_q <= Q1;
      end else begin
         q_q <= q_d;
      end
   end

   assign quarter = q_q;
   assign cycleEnd = (q_q == Q4);
endmodule
